// ---- rtl/port_mux_pkg.sv ----
// Constants, register map and field layout for the mode-dependent port pin multiplexer
`default_nettype none

package port_mux_pkg;

    typedef enum logic [1:0] {
        MODE_BOOT     = 2'h0,
        MODE_TEST     = 2'h1,
        MODE_SINGLE   = 2'h2,
        MODE_EXPANDED = 2'h3
    } op_mode_t;

    localparam logic [3:0] ADDR_TIMER_PORT   = 4'h0;
    localparam logic [3:0] ADDR_PA_CONTROL   = 4'h1;
    localparam logic [3:0] ADDR_HIGH_PORT    = 4'h2;
    localparam logic [3:0] ADDR_LOW_LATCHED  = 4'h3;
    localparam logic [3:0] ADDR_PIO_CONTROL  = 4'h4;
    localparam logic [3:0] ADDR_LOW_PORT     = 4'h5;
    localparam logic [3:0] ADDR_LOW_DIR      = 4'h6;
    localparam logic [3:0] ADDR_SERIAL_PORT  = 4'h7;
    localparam logic [3:0] ADDR_SERIAL_DIR   = 4'h8;
    localparam logic [3:0] ADDR_ANALOG_PORT  = 4'h9;
    localparam logic [3:0] ADDR_MODE_STATUS  = 4'hA;
    localparam logic [3:0] ADDR_MASTER_MASK  = 4'hB;
    localparam logic [3:0] ADDR_COMPARE_EN   = 4'hC;

    // Pulse accumulator control fields
    localparam int PAC_DIR_HI    = 7;
    localparam int PAC_DIR_MID   = 3;
    localparam int PAC_CAPTURE4  = 2;
    localparam int PAC_OC1_TRIG  = 1;
    // Parallel I/O control fields
    localparam int PIO_FLAG      = 7;
    localparam int PIO_STB_LEVEL = 4;
    localparam int PIO_EDGE_RISE = 3;
    localparam int PIO_HANDSHAKE = 2;
    localparam int PIO_STROBED   = 1;
    localparam int PIO_OPEN_DRN  = 0;

    localparam logic [7:0] PAC_RESET    = 8'h00;
    localparam logic [7:0] PIO_RESET    = 8'h00;
    localparam logic [7:0] PIO_WR_MASK  = 8'h1F;
    localparam logic [7:0] DATA_RESET   = 8'h00;
    localparam logic [7:0] UNMAPPED_VAL = 8'h00;
    localparam logic [7:0] TIMER_FIXED_OUT = 8'h70;

endpackage : port_mux_pkg

`default_nettype wire

// ---- rtl/port_pin_mux.sv ----
// Pin multiplexer and general-purpose ports for timer, high, low, serial and analogue ports
`default_nettype none

module port_pin_mux (
    // Clock and reset
    input  wire  logic        sys_clk,
    input  wire  logic        rst,
    // Mode-select straps
    input  wire  logic        mode_select_a,
    input  wire  logic        mode_select_b,
    // Register port
    input  wire  logic [3:0]  reg_addr,
    input  wire  logic [7:0]  reg_wdata,
    input  wire  logic        reg_wr,
    input  wire  logic        reg_rd,
    output logic       [7:0]  reg_rdata,
    output logic              reg_ext_hit,
    // Core bus cycle for expanded mode
    input  wire  logic [15:0] cyc_addr,
    input  wire  logic        cyc_read,
    input  wire  logic [7:0]  cyc_wdata,
    input  wire  logic        bus_clk_high,
    output logic       [7:0]  ext_rdata,
    // Timer functions
    input  wire  logic [7:3]  master_compare,
    input  wire  logic [6:3]  compare_level,
    output logic              pulse_accum_in,
    output logic       [3:0]  capture_in,
    // Serial functions
    input  wire  logic        sci_enable,
    input  wire  logic        sci_txd,
    input  wire  logic        spi_enable,
    input  wire  logic        spi_master,
    input  wire  logic        spi_mosi_out,
    input  wire  logic        spi_miso_out,
    input  wire  logic        spi_sck_out,
    output logic              sci_rxd,
    output logic              spi_data_in,
    output logic              spi_clk_in,
    output logic              spi_select,
    // Timer port pins
    input  wire  logic [7:0]  timer_pin_in,
    output logic       [7:0]  timer_pin_out,
    output logic       [7:0]  timer_pin_oe_n,
    // High-byte port pins
    output logic       [7:0]  high_pin_out,
    // Low-byte port pins
    input  wire  logic [7:0]  low_pin_in,
    output logic       [7:0]  low_pin_out,
    output logic       [7:0]  low_pin_oe_n,
    // Strobe pins
    input  wire  logic        input_strobe,
    output logic              output_strobe,
    output logic              address_latch_strobe,
    // Serial port pins
    input  wire  logic [5:0]  serial_pin_in,
    output logic       [5:0]  serial_pin_out,
    output logic       [5:0]  serial_pin_oe_n,
    // Analogue port pins
    input  wire  logic [7:0]  analog_pin_in
);

    // Register write and read decode, used by the register update process
    function automatic logic hit(input logic [3:0] a, input logic [3:0] target, input logic s);
        hit = s && (a == target);
    endfunction

    port_mux_pkg::op_mode_t mode;
    port_mux_pkg::op_mode_t next_mode;
    logic [7:0] timer_port_reg;
    logic [7:0] next_timer_port_reg;
    logic [7:0] pulse_accum_control_reg;
    logic [7:0] next_pulse_accum_control_reg;
    logic [7:0] high_byte_port_reg;
    logic [7:0] next_high_byte_port_reg;
    logic [7:0] low_port_latched_reg;
    logic [7:0] next_low_port_latched_reg;
    logic [7:0] parallel_io_control_reg;
    logic [7:0] next_parallel_io_control_reg;
    logic [7:0] low_port_reg;
    logic [7:0] next_low_port_reg;
    logic [7:0] low_dir_reg;
    logic [7:0] next_low_dir_reg;
    logic [5:0] serial_port_reg;
    logic [5:0] next_serial_port_reg;
    logic [5:0] serial_dir_reg;
    logic [5:0] next_serial_dir_reg;
    logic [7:3] master_mask_reg;
    logic [7:3] next_master_mask_reg;
    logic [6:3] compare_en_reg;
    logic [6:3] next_compare_en_reg;
    logic       strobe_prev;
    logic       next_strobe_prev;
    logic       strobe_pulse;
    logic       next_strobe_pulse;
    logic [7:0] rdata;
    logic [7:0] next_rdata;
    logic [7:0] ext_data;
    logic [7:0] next_ext_data;

    logic       expanded;
    logic       strobe_edge;
    logic [7:0] timer_drive;
    logic [7:0] timer_is_out;
    logic       low_open_drain;

    assign expanded = (mode == port_mux_pkg::MODE_EXPANDED) || (mode == port_mux_pkg::MODE_TEST);
    assign low_open_drain = parallel_io_control_reg[port_mux_pkg::PIO_OPEN_DRN] && !expanded;

    // Input strobe edge; the pin is already synchronous to sys_clk
    assign strobe_edge = parallel_io_control_reg[port_mux_pkg::PIO_EDGE_RISE]
                         ? (input_strobe && !strobe_prev)
                         : (!input_strobe && strobe_prev);

    // Mode is sampled throughout reset so the value at release is kept
    always_comb
    begin
        next_mode = mode;
        if (rst)
        begin
            next_mode = port_mux_pkg::op_mode_t'({mode_select_b, mode_select_a});
        end
    end

    always_comb
    begin
        next_timer_port_reg          = timer_port_reg;
        next_pulse_accum_control_reg = pulse_accum_control_reg;
        next_high_byte_port_reg      = high_byte_port_reg;
        next_low_port_latched_reg    = low_port_latched_reg;
        next_parallel_io_control_reg = parallel_io_control_reg;
        next_low_port_reg            = low_port_reg;
        next_low_dir_reg             = low_dir_reg;
        next_serial_port_reg         = serial_port_reg;
        next_serial_dir_reg          = serial_dir_reg;
        next_master_mask_reg         = master_mask_reg;
        next_compare_en_reg          = compare_en_reg;
        next_strobe_prev             = input_strobe;
        next_strobe_pulse            = 1'b0;
        next_ext_data                = ext_data;

        // Latch stores every bit; pin drive is decided separately
        if (hit(reg_addr, port_mux_pkg::ADDR_TIMER_PORT, reg_wr))
        begin
            next_timer_port_reg = reg_wdata;
        end
        if (hit(reg_addr, port_mux_pkg::ADDR_PA_CONTROL, reg_wr))
        begin
            next_pulse_accum_control_reg = reg_wdata;
        end
        // In expanded modes this address belongs to the outside world
        if (hit(reg_addr, port_mux_pkg::ADDR_HIGH_PORT, reg_wr) && !expanded)
        begin
            next_high_byte_port_reg = reg_wdata;
            next_strobe_pulse = parallel_io_control_reg[port_mux_pkg::PIO_STROBED];
        end
        if (hit(reg_addr, port_mux_pkg::ADDR_PIO_CONTROL, reg_wr))
        begin
            next_parallel_io_control_reg = (reg_wdata & port_mux_pkg::PIO_WR_MASK)
                | (parallel_io_control_reg & ~port_mux_pkg::PIO_WR_MASK);
        end
        if (hit(reg_addr, port_mux_pkg::ADDR_LOW_PORT, reg_wr))
        begin
            next_low_port_reg = reg_wdata;
        end
        if (hit(reg_addr, port_mux_pkg::ADDR_LOW_DIR, reg_wr))
        begin
            next_low_dir_reg = reg_wdata;
        end
        if (hit(reg_addr, port_mux_pkg::ADDR_SERIAL_PORT, reg_wr))
        begin
            next_serial_port_reg = reg_wdata[5:0];
        end
        if (hit(reg_addr, port_mux_pkg::ADDR_SERIAL_DIR, reg_wr))
        begin
            next_serial_dir_reg = reg_wdata[5:0];
        end
        if (hit(reg_addr, port_mux_pkg::ADDR_MASTER_MASK, reg_wr))
        begin
            next_master_mask_reg = reg_wdata[7:3];
        end
        if (hit(reg_addr, port_mux_pkg::ADDR_COMPARE_EN, reg_wr))
        begin
            next_compare_en_reg = reg_wdata[6:3];
        end

        // Reading the latched data clears the flag; a new edge in that cycle still wins
        if (hit(reg_addr, port_mux_pkg::ADDR_LOW_LATCHED, reg_rd))
        begin
            next_parallel_io_control_reg[port_mux_pkg::PIO_FLAG] = 1'b0;
        end
        if (strobe_edge && !expanded)
        begin
            next_low_port_latched_reg = low_pin_in;
            next_parallel_io_control_reg[port_mux_pkg::PIO_FLAG] = 1'b1;
        end

        // Outside data is taken while the bus clock is high on a read cycle
        if (expanded && bus_clk_high && cyc_read)
        begin
            next_ext_data = low_pin_in;
        end
    end

    // Timer port pin functions, identical in every mode
    always_comb
    begin
        timer_is_out = port_mux_pkg::TIMER_FIXED_OUT;
        timer_is_out[7] = pulse_accum_control_reg[port_mux_pkg::PAC_DIR_HI];
        timer_is_out[3] = pulse_accum_control_reg[port_mux_pkg::PAC_DIR_MID];
        timer_drive = timer_port_reg;
        for (int i = 3; i < 7; i++)
        begin
            if (compare_en_reg[i])
            begin
                timer_drive[i] = compare_level[i];
            end
        end
        if (pulse_accum_control_reg[port_mux_pkg::PAC_CAPTURE4])
        begin
            timer_drive[3] = timer_port_reg[3];
        end
        for (int i = 3; i < 8; i++)
        begin
            if (master_mask_reg[i])
            begin
                timer_drive[i] = master_compare[i];
            end
        end
    end

    assign timer_pin_out  = timer_drive;
    assign timer_pin_oe_n = ~timer_is_out;
    // Driven pin feeds its own level, so the accumulator follows the output too
    assign pulse_accum_in = timer_is_out[7] ? timer_drive[7] : timer_pin_in[7];
    assign capture_in[2:0] = timer_pin_in[2:0];
    // Capture 4 sees master compare edges when capture 4, the trigger option and mask bit 3 are all set
    assign capture_in[3] = !pulse_accum_control_reg[port_mux_pkg::PAC_CAPTURE4] ? 1'b0
        : (pulse_accum_control_reg[port_mux_pkg::PAC_OC1_TRIG] && master_mask_reg[3])
          ? master_compare[3] : timer_pin_in[3];

    // High-byte port: outputs only, or upper address in expanded modes
    assign high_pin_out = expanded ? cyc_addr[15:8] : high_byte_port_reg;

    // Low-byte port
    always_comb
    begin
        if (expanded)
        begin
            if (!bus_clk_high)
            begin
                low_pin_out  = cyc_addr[7:0];
                low_pin_oe_n = 8'h00;
            end
            else
            begin
                low_pin_out  = cyc_wdata;
                low_pin_oe_n = {8{cyc_read}};
            end
        end
        else if (low_open_drain)
        begin
            low_pin_out  = 8'h00;
            low_pin_oe_n = ~(low_dir_reg & ~low_port_reg);
        end
        else
        begin
            low_pin_out  = low_port_reg;
            low_pin_oe_n = ~low_dir_reg;
        end
    end

    // Strobe pins change role with mode
    assign address_latch_strobe = expanded && !bus_clk_high;
    always_comb
    begin
        if (expanded)
        begin
            output_strobe = cyc_read;
        end
        else if (parallel_io_control_reg[port_mux_pkg::PIO_HANDSHAKE])
        begin
            // Active while data is waiting in the latch, until the latched data is read
            output_strobe = parallel_io_control_reg[port_mux_pkg::PIO_STB_LEVEL]
                            ^ parallel_io_control_reg[port_mux_pkg::PIO_FLAG];
        end
        else
        begin
            output_strobe = parallel_io_control_reg[port_mux_pkg::PIO_STB_LEVEL]
                            ^ strobe_pulse;
        end
    end

    // Serial port: subsystem functions override the plain I/O bits
    always_comb
    begin
        serial_pin_out  = serial_port_reg;
        serial_pin_oe_n = ~serial_dir_reg;
        if (sci_enable)
        begin
            serial_pin_oe_n[0] = 1'b1;
            serial_pin_out[1]  = sci_txd;
            serial_pin_oe_n[1] = 1'b0;
        end
        if (spi_enable)
        begin
            serial_pin_out[2]  = spi_miso_out;
            serial_pin_oe_n[2] = spi_master;
            serial_pin_out[3]  = spi_mosi_out;
            serial_pin_oe_n[3] = !spi_master;
            serial_pin_out[4]  = spi_sck_out;
            serial_pin_oe_n[4] = !spi_master;
            serial_pin_oe_n[5] = 1'b1;
        end
    end
    assign sci_rxd     = serial_pin_in[0];
    assign spi_data_in = spi_master ? serial_pin_in[2] : serial_pin_in[3];
    assign spi_clk_in  = serial_pin_in[4];
    assign spi_select  = serial_pin_in[5];

    // Register read data, valid in the cycle after the strobe
    always_comb
    begin
        next_rdata = port_mux_pkg::UNMAPPED_VAL;
        if (reg_rd)
        begin
            unique case (reg_addr)
                port_mux_pkg::ADDR_TIMER_PORT:
                    next_rdata = (timer_is_out & timer_drive)
                                 | (~timer_is_out & timer_pin_in);
                port_mux_pkg::ADDR_PA_CONTROL:  next_rdata = pulse_accum_control_reg;
                port_mux_pkg::ADDR_HIGH_PORT:
                    next_rdata = expanded ? port_mux_pkg::UNMAPPED_VAL
                                          : high_byte_port_reg;
                port_mux_pkg::ADDR_LOW_LATCHED: next_rdata = low_port_latched_reg;
                port_mux_pkg::ADDR_PIO_CONTROL: next_rdata = parallel_io_control_reg;
                port_mux_pkg::ADDR_LOW_PORT:
                    next_rdata = (low_dir_reg & low_port_reg) | (~low_dir_reg & low_pin_in);
                port_mux_pkg::ADDR_LOW_DIR:     next_rdata = low_dir_reg;
                port_mux_pkg::ADDR_SERIAL_PORT:
                    next_rdata = {2'h0, (serial_dir_reg & serial_port_reg)
                                        | (~serial_dir_reg & serial_pin_in)};
                port_mux_pkg::ADDR_SERIAL_DIR:  next_rdata = {2'h0, serial_dir_reg};
                // Reading here during a conversion sample may disturb its accuracy
                port_mux_pkg::ADDR_ANALOG_PORT: next_rdata = analog_pin_in;
                port_mux_pkg::ADDR_MODE_STATUS: next_rdata = {6'h00, mode};
                port_mux_pkg::ADDR_MASTER_MASK: next_rdata = {master_mask_reg, 3'h0};
                port_mux_pkg::ADDR_COMPARE_EN:  next_rdata = {1'b0, compare_en_reg, 3'h0};
                default:                        next_rdata = port_mux_pkg::UNMAPPED_VAL;
            endcase
        end
    end

    assign reg_ext_hit = expanded && (reg_addr == port_mux_pkg::ADDR_HIGH_PORT)
                         && (reg_wr || reg_rd);
    assign reg_rdata   = rdata;
    assign ext_rdata   = ext_data;

    // Mode holds across everything but reset
    always_ff @(posedge sys_clk)
    begin
        mode <= next_mode;
    end

    always_ff @(posedge sys_clk)
    begin
        if (rst)
        begin
            timer_port_reg          <= port_mux_pkg::DATA_RESET;
            pulse_accum_control_reg <= port_mux_pkg::PAC_RESET;
            high_byte_port_reg      <= port_mux_pkg::DATA_RESET;
            low_port_latched_reg    <= port_mux_pkg::DATA_RESET;
            parallel_io_control_reg <= port_mux_pkg::PIO_RESET;
            low_port_reg            <= port_mux_pkg::DATA_RESET;
            low_dir_reg             <= port_mux_pkg::DATA_RESET;
            serial_port_reg         <= 6'h00;
            serial_dir_reg          <= 6'h00;
            master_mask_reg         <= 5'h00;
            compare_en_reg          <= 4'h0;
            strobe_prev             <= 1'b0;
            strobe_pulse            <= 1'b0;
            rdata                   <= port_mux_pkg::DATA_RESET;
            ext_data                <= port_mux_pkg::DATA_RESET;
        end
        else
        begin
            timer_port_reg          <= next_timer_port_reg;
            pulse_accum_control_reg <= next_pulse_accum_control_reg;
            high_byte_port_reg      <= next_high_byte_port_reg;
            low_port_latched_reg    <= next_low_port_latched_reg;
            parallel_io_control_reg <= next_parallel_io_control_reg;
            low_port_reg            <= next_low_port_reg;
            low_dir_reg             <= next_low_dir_reg;
            serial_port_reg         <= next_serial_port_reg;
            serial_dir_reg          <= next_serial_dir_reg;
            master_mask_reg         <= next_master_mask_reg;
            compare_en_reg          <= next_compare_en_reg;
            strobe_prev             <= next_strobe_prev;
            strobe_pulse            <= next_strobe_pulse;
            rdata                   <= next_rdata;
            ext_data                <= next_ext_data;
        end
    end

endmodule // port_pin_mux

`default_nettype wire

// ---- bench/port_pin_mux_chk.sv ----
// Assertion checker for the mode-dependent port pin multiplexer
`default_nettype none
module port_pin_mux_chk (
    // Clock, reset and mode-select strap a
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        mode_select_a,
    // Register port
    input wire logic [3:0]  reg_addr,
    input wire logic        reg_wr,
    input wire logic        reg_rd,
    input wire logic        reg_ext_hit,
    // Core bus cycle
    input wire logic [15:0] cyc_addr,
    input wire logic        cyc_read,
    input wire logic [7:0]  cyc_wdata,
    input wire logic        bus_clk_high,
    input wire logic [7:0]  ext_rdata,
    // Pins
    input wire logic [7:0]  low_pin_in,
    input wire logic [7:0]  low_pin_out,
    input wire logic [7:0]  low_pin_oe_n,
    input wire logic [7:0]  high_pin_out,
    input wire logic        output_strobe,
    input wire logic [7:0]  timer_pin_in,
    input wire logic [7:0]  timer_pin_oe_n,
    input wire logic        pulse_accum_in
);
    timeunit 1ns;
    timeprecision 1ns;
    // Test and expanded modes both have strap a set
    logic exp_mode;
    logic next_exp_mode;
    always_comb next_exp_mode = rst ? mode_select_a : exp_mode;
    always_ff @(posedge sys_clk) exp_mode <= next_exp_mode;
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (rst);
    sequence s_data_rd;
        exp_mode && bus_clk_high && cyc_read;
    endsequence
    sequence s_data_wr;
        exp_mode && bus_clk_high && !cyc_read;
    endsequence
    a_high_addr: assert property (exp_mode |-> high_pin_out == cyc_addr[15:8])
        else $error("high port not address");
    a_low_addr: assert property (exp_mode && !bus_clk_high |->
        low_pin_out == cyc_addr[7:0] && low_pin_oe_n == 8'h00)
        else $error("low port not address");
    a_read_float: assert property (s_data_rd |-> low_pin_oe_n == 8'hFF)
        else $error("low port driven on read");
    a_write_data: assert property (s_data_wr |->
        low_pin_out == cyc_wdata && low_pin_oe_n == 8'h00)
        else $error("write data not driven");
    a_rw_line: assert property (exp_mode |-> output_strobe == cyc_read)
        else $error("read write line wrong");
    a_ext_decode: assert property (exp_mode && (reg_wr || reg_rd) && reg_addr == 4'h2
        |-> reg_ext_hit)
        else $error("high port not external");
    a_read_take: assert property (s_data_rd |=> ext_rdata == $past(low_pin_in))
        else $error("read data not taken");
    a_accum_feed: assert property (timer_pin_oe_n[7] |-> pulse_accum_in == timer_pin_in[7])
        else $error("accumulator input wrong");
endmodule // port_pin_mux_chk
`default_nettype wire

// ---- bench/port_mux_ext_mem.sv ----
// Behavioural memory on the multiplexed address/data bus
`default_nettype none
module port_mux_ext_mem (
    input  wire logic       sys_clk,
    input  wire logic [7:0] low_bus,
    input  wire logic       addr_strobe,
    input  wire logic       rd_wr,
    input  wire logic       data_phase,
    output logic      [7:0] mem_data
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [0:15];
    logic [3:0] low_addr;
    logic [7:0] last = 8'h00;
    logic       mem_oe;
    assign mem_oe = data_phase && rd_wr;
    // Released bus shows the inverse of the last byte, never a stale copy
    assign mem_data = mem_oe ? mem[low_addr] : ~last;
    always @(posedge sys_clk)
    begin
        if (addr_strobe)
            low_addr <= low_bus[3:0];
        if (data_phase && !rd_wr)
            mem[low_addr] <= low_bus;
        if (mem_oe)
            last <= mem_data;
    end
endmodule // port_mux_ext_mem
`default_nettype wire

// ---- bench/mode_dependent_port_pin_mux_test.sv ----
// Self-checking bench for the mode-dependent port pin multiplexer
`default_nettype none
module mode_dependent_port_pin_mux_test;
    timeunit 1ns;
    timeprecision 1ns;
    logic sys_clk = 1'h0, rst = 1'h1, mode_select_a = 1'h0, mode_select_b = 1'h1;
    logic reg_wr = 1'h0, reg_rd = 1'h0, cyc_read = 1'h1, bus_clk_high = 1'h0;
    logic sci_enable = 1'h0, sci_txd = 1'h0, input_strobe = 1'h0, low_drive_en = 1'h0;
    logic spi_enable = 1'h0, spi_master = 1'h0, spi_mosi_out = 1'h0;
    logic spi_miso_out = 1'h0, spi_sck_out = 1'h0;
    logic [3:0] reg_addr = 4'h0;
    logic [7:0] reg_wdata = 8'h00, cyc_wdata = 8'h00, timer_drive = 8'h00;
    logic [7:0] low_drive = 8'h00, analog_pin_in = 8'h5C;
    logic [15:0] cyc_addr = 16'h0000;
    logic [7:3] master_compare = 5'h00;
    logic [6:3] compare_level = 4'h0;
    logic [5:0] serial_pin_in = 6'h00;
    logic [7:0] reg_rdata, ext_rdata, timer_pin_in, timer_pin_out, timer_pin_oe_n;
    logic [7:0] high_pin_out, low_pin_in, low_pin_out, low_pin_oe_n, mem_data;
    logic reg_ext_hit, pulse_accum_in, output_strobe, address_latch_strobe, sci_rxd;
    logic spi_data_in, spi_clk_in, spi_select;
    logic [3:0] capture_in;
    logic [5:0] serial_pin_out, serial_pin_oe_n;
    int n_errors = 0, total_checks = 0, cycles = 0, n;
    assign timer_pin_in = (timer_pin_out & ~timer_pin_oe_n) | (timer_drive & timer_pin_oe_n);
    assign low_pin_in = (low_pin_out & ~low_pin_oe_n)
        | ((low_drive_en ? low_drive : mem_data) & low_pin_oe_n);
    port_pin_mux i_port_pin_mux (.*);
    port_mux_ext_mem i_port_mux_ext_mem (.sys_clk(sys_clk), .low_bus(low_pin_in),
        .addr_strobe(address_latch_strobe), .rd_wr(output_strobe),
        .data_phase(bus_clk_high), .mem_data(mem_data));
    initial forever #25 sys_clk = ~sys_clk;
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            n_errors++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'h1;
        @(posedge sys_clk);
        reg_wr <= 1'h0;
        #1;
    endtask
    task automatic rd_chk(input logic [3:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'h1;
        @(posedge sys_clk);
        reg_rd <= 1'h0;
        #1 chk(reg_rdata, exp);
    endtask
    task automatic bus(input logic [15:0] a, input logic r, input logic [7:0] d);
        @(posedge sys_clk);
        cyc_addr <= a;
        cyc_read <= r;
        cyc_wdata <= d;
        repeat (2) @(posedge sys_clk);
        bus_clk_high <= 1'h1;
        repeat (2) @(posedge sys_clk);
        bus_clk_high <= 1'h0;
        #1;
    endtask
    task automatic t_timer;
        wr(4'h1, 8'h88);
        wr(4'h0, 8'hFF);
        chk(timer_pin_oe_n, 8'h07);
        rd_chk(4'h0, 8'hF8);
        timer_drive <= 8'h8A;
        wr(4'h1, 8'h00);
        rd_chk(4'h0, 8'hFA);
        chk(pulse_accum_in, 1'h1);
        master_compare <= 5'h04;
        wr(4'hB, 8'h20);
        wr(4'h0, 8'h00);
        chk(timer_pin_out[6:4], 3'h2);
        timer_drive <= 8'h05;
        master_compare <= 5'h05;
        wr(4'hB, 8'h28);
        wr(4'h1, 8'h06);
        chk(capture_in, 4'hD);
        timer_drive <= 8'h0D;
        master_compare <= 5'h04;
        wr(4'h1, 8'h04);
        chk(capture_in[3], 1'h1);
        compare_level <= 4'h1;
        wr(4'hB, 8'h00);
        wr(4'hC, 8'h08);
        wr(4'h1, 8'h08);
        chk({timer_pin_oe_n[3], timer_pin_out[3], capture_in[3]}, 3'h2);
    endtask
    task automatic t_serial;
        @(posedge sys_clk);
        serial_pin_in <= 6'h21;
        sci_enable <= 1'h1;
        sci_txd <= 1'h1;
        spi_enable <= 1'h1;
        spi_master <= 1'h1;
        spi_mosi_out <= 1'h1;
        spi_sck_out <= 1'h1;
        @(posedge sys_clk);
        #1 chk(serial_pin_out, 6'h1A);
        chk(serial_pin_oe_n, 6'h25);
        chk({sci_rxd, spi_data_in, spi_clk_in, spi_select}, 4'h9);
        sci_enable <= 1'h0;
        spi_enable <= 1'h0;
        wr(4'h8, 8'h3F);
        wr(4'h7, 8'h15);
        chk(serial_pin_out, 6'h15);
        chk(serial_pin_oe_n, 6'h00);
        rd_chk(4'h7, 8'h15);
    endtask
    task automatic t_ports;
        wr(4'h2, 8'hA5);
        chk(high_pin_out, 8'hA5);
        rd_chk(4'h2, 8'hA5);
        wr(4'h4, 8'h02);
        wr(4'h2, 8'h3C);
        n = 0;
        repeat (4)
        begin
            n += output_strobe;
            @(posedge sys_clk);
            #1;
        end
        chk(n, 1);
        wr(4'h4, 8'h08);
        low_drive_en <= 1'h1;
        low_drive <= 8'h3C;
        input_strobe <= 1'h1;
        repeat (3) @(posedge sys_clk);
        low_drive <= 8'hC3;
        rd_chk(4'h3, 8'h3C);
        wr(4'h4, 8'h04);
        chk(output_strobe, 1'h0);
        input_strobe <= 1'h0;
        @(posedge sys_clk);
        #1 chk(output_strobe, 1'h1);
        rd_chk(4'h3, 8'hC3);
        chk(output_strobe, 1'h0);
        low_drive_en <= 1'h0;
        wr(4'h4, 8'h01);
        wr(4'h6, 8'hFF);
        wr(4'h5, 8'h0F);
        chk({low_pin_oe_n, low_pin_out & ~low_pin_oe_n}, 16'h0F00);
        rd_chk(4'h9, 8'h5C);
        rd_chk(4'hE, 8'h00);
    endtask
    task automatic t_bus;
        @(posedge sys_clk);
        rst <= 1'h1;
        mode_select_a <= 1'h1;
        repeat (4) @(posedge sys_clk);
        rst <= 1'h0;
        mode_select_a <= 1'h0;
        wr(4'h4, 8'h01);
        bus(16'h1234, 1'h0, 8'h5A);
        bus(16'hAB34, 1'h1, 8'h00);
        chk(ext_rdata, 8'h5A);
        chk(high_pin_out, 8'hAB);
        wr(4'h2, 8'h77);
        rd_chk(4'h2, 8'h00);
        rd_chk(4'hA, 8'h03);
    endtask
    task automatic test_done;
        if (n_errors == 0 && total_checks > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    always @(posedge sys_clk)
    begin
        cycles++;
        if (cycles == 3000)
        begin
            n_errors++;
            test_done();
        end
    end
    initial
    begin
        repeat (4) @(posedge sys_clk);
        rst <= 1'h0;
        t_timer();
        t_ports();
        t_serial();
        t_bus();
        test_done();
    end
endmodule // mode_dependent_port_pin_mux_test
bind port_pin_mux port_pin_mux_chk i_port_pin_mux_chk (.*);
`default_nettype wire
